// ---- design/dshp_pkg.sv ----
// Purpose: Shared constants and types for the dual serial host port.
// Assumes: 125 MHz system clock on both ends.
// Notes: Notes on behaviour follow.
// Notes on behaviour
// RULE1: Strap low selects SPI, high selects I2C.
// RULE2: SPI logic held reset while chip enable high; the SPI write word and its toggle are kept across chip enable.
// RULE3: Host deasserts chip enable between transactions.
// RULE4: SPI input sampled on serial clock rise.
// RULE5: SPI output updated on serial clock fall.
// RULE6: Whole bytes, most significant bit first.
// RULE7: First SPI byte is command, rest data.
// RULE8: Command bit 7: zero writes, one reads.
// RULE9: Command bits 6..0 give start index.
// RULE10: Index increments per byte, wraps after 36h.
// RULE11: I2C data stable while clock high.
// RULE12: Start and stop detected while clock high.
// RULE13: Device is I2C target only, never clocks.
// RULE14: Each byte followed by one acknowledge clock.
// RULE15: Device acknowledges received bytes low during high.
// RULE16: Host nacks last read byte; device releases.
// RULE17: Device answers only target address 1010011.
// RULE18: Address bit 0: one reads, zero writes.
// RULE19: Host ends I2C writes with stop.
// RULE20: Both interfaces inactive on backup battery; SPI still shifts two bits and drives output low one bit per selection.
// RULE21: Battery switchover ends I2C transaction in progress.
// RULE22: Host sends stop then start after outage.
// RULE23: Unmatched address: release line, ignore until start.
// RULE24: First I2C write byte sets register index.
package dshp_pkg;
  localparam logic [6:0] IDX_MAX = 7'h36;
  localparam logic [6:0] I2C_ADDR = 7'h53;
  localparam int CMD_DIR_POS = 7;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int SYS_HZ = 125_000_000;
  localparam int SPI_MAX_HZ = 6_500_000;
  localparam int I2C_MAX_HZ = 400_000;
  // Quarter periods of the serial clock, rounded up so the rate stays under its limit
  localparam int SPI_QUARTER = (SYS_HZ + 4 * SPI_MAX_HZ - 1) / (4 * SPI_MAX_HZ);
  localparam int I2C_QUARTER = (SYS_HZ + 4 * I2C_MAX_HZ - 1) / (4 * I2C_MAX_HZ);
  localparam int QCNT_W = 8;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_ADDR = 3'b001, I_ACK = 3'b011, I_RECV = 3'b010,
    I_SEND = 3'b110, I_CHK = 3'b111, I_SKIP = 3'b101
  } dshp_i2c_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_START = 3'b001, H_BITS = 3'b011, H_STOP = 3'b010, H_DONE = 3'b110
  } dshp_host_e;

  // Next register index with wrap after the last valid one
  function automatic logic [6:0] idx_next(input logic [6:0] idx);
    return (idx >= IDX_MAX) ? 7'h00 : 7'(idx + 7'h01);
  endfunction : idx_next
endpackage : dshp_pkg

// ---- design/dshp_link_if.sv ----
// Purpose: Shared pins between host controller and device.
// Assumes: Pull-ups on the shared data/enable line and on the output line.
// Notes: Wire levels resolved here from drivers and enables.
`timescale 1ns/100ps
interface dshp_link_if;
  logic host_scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic host_sdi;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic dev_sdo;
  logic dev_sdo_oe;
  logic scl;
  logic sda_ce;
  logic serial_in_line;
  logic serial_out_line;

  // Pulled-up wire: any enabled low driver wins
  assign scl = host_scl;
  assign sda_ce = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);
  assign serial_in_line = host_sdi;
  assign serial_out_line = dev_sdo_oe ? dev_sdo : 1'b1;

  modport device (input scl, input sda_ce, input serial_in_line,
    output dev_sda_out, output dev_sda_oe, output dev_sdo, output dev_sdo_oe);
  modport host (input sda_ce, input serial_out_line,
    output host_scl, output host_sda_out, output host_sda_oe, output host_sdi);
endinterface : dshp_link_if

// ---- design/dshp_device.sv ----
// Purpose: Device end: SPI target on the link clock, I2C target oversampled.
// Assumes: spi_rdata_in is a mux of static registers by spi_index_out.
// Notes: SPI writes cross to the system clock by a toggle.
`timescale 1ns/100ps
module dshp_device (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  dshp_link_if.device link,
  input wire logic protocol_strap_pin_in,
  input wire logic battery_mode_in,
  output logic [6:0] reg_index_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in,
  output logic [6:0] spi_index_out,
  input wire logic [7:0] spi_rdata_in
);
  logic [1:0] strap_sync_reg, batt_sync_reg, scl_sync_reg, sda_sync_reg;
  logic scl_d_reg, sda_d_reg, link_rst_reg;
  logic [2:0] wtog_sync_reg;
  dshp_pkg::dshp_i2c_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, rd_hold_reg;
  logic dir_reg, first_reg, more_reg, rd_wait_reg, sda_oe_reg;
  logic [6:0] i2c_idx_reg, reg_index_reg;
  logic [7:0] reg_wdata_reg;
  logic reg_wr_reg, reg_rd_reg;
  // Link-domain state
  logic [1:0] strap_l_reg, batt_l_reg;
  logic [2:0] spi_cnt_reg;
  logic [6:0] spi_sh_reg, spi_idx_reg, spi_widx_reg;
  logic spi_first_reg, spi_dir_reg, spi_wtog_reg;
  logic [7:0] spi_wdata_reg, out_sh_reg;
  logic sdo_reg, sdo_oe_reg;

  // Pin and level synchronisers on the system clock
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      strap_sync_reg <= 2'h0;
      batt_sync_reg <= 2'h0;
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      wtog_sync_reg <= 3'h0;
    end else begin
      strap_sync_reg <= {strap_sync_reg[0], protocol_strap_pin_in};
      batt_sync_reg <= {batt_sync_reg[0], battery_mode_in};
      scl_sync_reg <= {scl_sync_reg[0], link.scl};
      sda_sync_reg <= {sda_sync_reg[0], link.sda_ce};
      wtog_sync_reg <= {wtog_sync_reg[1:0], spi_wtog_reg};
    end
  end

  // Condition decode on the synchronised bus lines
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire i2c_on = strap_sync_reg[1] & ~batt_sync_reg[1]; // RULE1 RULE20
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // RULE12
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s; // RULE12
  wire byte_done = scl_fall && (bit_cnt_reg == dshp_pkg::BYTE_BITS);
  wire addr_match = (shift_reg[7:1] == dshp_pkg::I2C_ADDR); // RULE17
  wire spi_wr_evt = wtog_sync_reg[2] ^ wtog_sync_reg[1];
  wire [6:0] i2c_idx_inc = dshp_pkg::idx_next(i2c_idx_reg);

  // Link reset source, a plain flop so the async clear sees a clean level
  always_ff @(posedge clk_sys_in) begin
    link_rst_reg <= srst_in;
  end

  // I2C target engine and user register strobes
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= dshp_pkg::I_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rd_hold_reg <= 8'h00;
      dir_reg <= 1'b0;
      first_reg <= 1'b1;
      more_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      i2c_idx_reg <= 7'h00;
      reg_index_reg <= 7'h00;
      reg_wdata_reg <= 8'h00;
      reg_wr_reg <= 1'b0;
      reg_rd_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      reg_wr_reg <= 1'b0;
      reg_rd_reg <= 1'b0;
      rd_wait_reg <= reg_rd_reg;
      if (rd_wait_reg) begin
        rd_hold_reg <= reg_rdata_in;
      end
      // SPI write word is held stable in the link domain for a whole byte
      if (spi_wr_evt) begin
        reg_wr_reg <= 1'b1;
        reg_index_reg <= spi_widx_reg;
        reg_wdata_reg <= spi_wdata_reg;
      end
      if (!i2c_on || stop_det) begin
        state_reg <= dshp_pkg::I_IDLE; // RULE21
        sda_oe_reg <= 1'b0;
      end else if (start_det) begin
        state_reg <= dshp_pkg::I_ADDR;
        bit_cnt_reg <= 4'h0;
        first_reg <= 1'b1;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          dshp_pkg::I_ADDR, dshp_pkg::I_RECV: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s}; // RULE11 RULE6
              bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            end else if (byte_done) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == dshp_pkg::I_ADDR) begin
                if (addr_match) begin
                  sda_oe_reg <= 1'b1; // RULE15
                  dir_reg <= shift_reg[0]; // RULE18
                  state_reg <= dshp_pkg::I_ACK;
                  reg_rd_reg <= shift_reg[0];
                  reg_index_reg <= i2c_idx_reg;
                end else begin
                  state_reg <= dshp_pkg::I_SKIP; // RULE23
                end
              end else begin
                sda_oe_reg <= 1'b1; // RULE15 RULE14
                state_reg <= dshp_pkg::I_ACK;
                if (first_reg) begin
                  i2c_idx_reg <= shift_reg[6:0]; // RULE24
                  first_reg <= 1'b0;
                end else begin
                  reg_wr_reg <= 1'b1;
                  reg_index_reg <= i2c_idx_reg;
                  reg_wdata_reg <= shift_reg;
                  i2c_idx_reg <= i2c_idx_inc; // RULE10
                end
              end
            end
          end
          dshp_pkg::I_ACK, dshp_pkg::I_CHK: begin
            if (scl_rise && state_reg == dshp_pkg::I_CHK) begin
              more_reg <= ~sda_s;
              reg_rd_reg <= ~sda_s;
              reg_index_reg <= i2c_idx_reg;
            end else if (scl_fall) begin
              if (dir_reg && (state_reg == dshp_pkg::I_ACK || more_reg)) begin
                shift_reg <= rd_hold_reg;
                sda_oe_reg <= ~rd_hold_reg[7]; // RULE13
                bit_cnt_reg <= 4'h0;
                i2c_idx_reg <= i2c_idx_inc; // RULE10
                state_reg <= dshp_pkg::I_SEND;
              end else begin
                sda_oe_reg <= 1'b0;
                state_reg <= dir_reg ? dshp_pkg::I_SKIP : dshp_pkg::I_RECV; // RULE16
              end
            end
          end
          dshp_pkg::I_SEND: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h7) begin
                sda_oe_reg <= 1'b0; // RULE14
                state_reg <= dshp_pkg::I_CHK;
              end else begin
                sda_oe_reg <= ~shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Strap level on the link clock, cleared by system reset so the first bits are not lost
  always_ff @(posedge link.scl or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      strap_l_reg <= 2'h0;
    end else begin
      strap_l_reg <= {strap_l_reg[0], protocol_strap_pin_in};
    end
  end

  // Battery level on the link clock; the serial clock idles between selections, so
  // clearing with chip enable keeps a stale level from eating the next command
  always_ff @(posedge link.scl or posedge link.sda_ce) begin
    if (link.sda_ce) begin
      batt_l_reg <= 2'h0;
    end else begin
      batt_l_reg <= {batt_l_reg[0], battery_mode_in};
    end
  end

  wire spi_on_l = ~strap_l_reg[1] & ~batt_l_reg[1]; // RULE1 RULE20
  wire [7:0] spi_byte = {spi_sh_reg, link.serial_in_line};
  wire spi_last = (spi_cnt_reg == 3'h7);

  // SPI receive side, cleared while chip enable is high
  always_ff @(posedge link.scl or posedge link.sda_ce) begin
    if (link.sda_ce) begin // RULE2
      spi_cnt_reg <= 3'h0;
      spi_sh_reg <= 7'h00;
      spi_first_reg <= 1'b1;
      spi_dir_reg <= 1'b0;
      spi_idx_reg <= 7'h00;
    end else if (spi_on_l) begin
      spi_sh_reg <= spi_byte[6:0]; // RULE4 RULE6
      spi_cnt_reg <= 3'(spi_cnt_reg + 3'h1);
      if (spi_last && spi_first_reg) begin
        spi_first_reg <= 1'b0; // RULE7
        spi_dir_reg <= spi_byte[dshp_pkg::CMD_DIR_POS]; // RULE8
        spi_idx_reg <= spi_byte[6:0]; // RULE9
      end else if (spi_last) begin
        spi_idx_reg <= dshp_pkg::idx_next(spi_idx_reg); // RULE10
      end
    end
  end

  // SPI write word, kept across chip enable so the crossing completes
  always_ff @(posedge link.scl or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      spi_wtog_reg <= 1'b0;
      spi_wdata_reg <= 8'h00;
      spi_widx_reg <= 7'h00;
    end else if (spi_on_l && spi_last && !spi_first_reg && spi_dir_reg != dshp_pkg::DIR_READ) begin
      spi_wdata_reg <= spi_byte;
      spi_widx_reg <= spi_idx_reg;
      spi_wtog_reg <= ~spi_wtog_reg;
    end
  end

  // SPI transmit side on the falling edge
  always_ff @(negedge link.scl or posedge link.sda_ce) begin
    if (link.sda_ce) begin
      out_sh_reg <= 8'h00;
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= spi_on_l;
      if (spi_cnt_reg == 3'h0 && !spi_first_reg && spi_dir_reg == dshp_pkg::DIR_READ) begin
        out_sh_reg <= spi_rdata_in; // RULE5
        sdo_reg <= spi_rdata_in[7];
      end else begin
        out_sh_reg <= {out_sh_reg[6:0], 1'b0}; // RULE5 RULE6
        sdo_reg <= out_sh_reg[6];
      end
    end
  end

  // Output drive
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = sda_oe_reg;
  assign link.dev_sdo = sdo_reg;
  assign link.dev_sdo_oe = sdo_oe_reg;
  assign reg_index_out = reg_index_reg;
  assign reg_wdata_out = reg_wdata_reg;
  assign reg_wr_out = reg_wr_reg;
  assign reg_rd_out = reg_rd_reg;
  assign spi_index_out = spi_idx_reg;
endmodule : dshp_device

// ---- design/dshp_host.sv ----
// Purpose: Host end: single-byte register reads and writes over SPI or I2C.
// Assumes: i2c_mode_in is static and matches the device strap.
// Notes: Serial clock made here from the system clock by a quarter divider.
`timescale 1ns/100ps
module dshp_host #(
  parameter int SPI_Q = dshp_pkg::SPI_QUARTER,
  parameter int I2C_Q = dshp_pkg::I2C_QUARTER
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  dshp_link_if.host link,
  input wire logic i2c_mode_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_read_in,
  input wire logic [6:0] cmd_index_in,
  input wire logic [7:0] cmd_wdata_in,
  input wire logic recover_in,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic nack_out
);
  dshp_pkg::dshp_host_e state_reg;
  logic [dshp_pkg::QCNT_W-1:0] q_cnt_reg;
  logic [1:0] phase_reg, k_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] tx_reg, rx_reg, wd_reg;
  logic [6:0] idx_reg;
  logic [1:0] sdo_sync_reg, sda_sync_reg;
  logic rd_reg, i2c_reg, rec_reg, nack_reg, scl_reg, sda_oe_reg, sda_val_reg, done_reg, sdi_reg;

  // Byte sent in slot k; all inputs are arguments so the wires below follow every change
  function automatic logic [7:0] byte_for(input logic [1:0] k, input logic i2c, input logic rd,
    input logic [6:0] idx, input logic [7:0] wd);
    if (!i2c) begin
      return (k == 2'h0) ? {rd, idx} : (rd ? 8'hFF : wd);
    end
    case (k)
      2'h0: return {dshp_pkg::I2C_ADDR, 1'b0};
      2'h1: return {1'b0, idx};
      2'h2: return rd ? {dshp_pkg::I2C_ADDR, 1'b1} : wd;
      default: return 8'hFF;
    endcase
  endfunction : byte_for

  wire tick = (q_cnt_reg == '0);
  wire [dshp_pkg::QCNT_W-1:0] q_load = dshp_pkg::QCNT_W'((i2c_mode_in ? I2C_Q : SPI_Q) - 1);
  wire [1:0] last_k = i2c_reg ? (rd_reg ? 2'h3 : 2'h2) : 2'h1;
  wire [3:0] nbits = i2c_reg ? 4'h9 : dshp_pkg::BYTE_BITS; // RULE14
  wire byte_end = (bit_cnt_reg == 4'(nbits - 4'h1));
  wire stop_here = (k_reg == last_k) || (i2c_reg && rd_reg && k_reg == 2'h1); // RULE19 RULE3
  wire ack_bit = i2c_reg && bit_cnt_reg == dshp_pkg::BYTE_BITS;
  wire [7:0] next_byte = byte_for(2'(k_reg + 2'h1), i2c_reg, rd_reg, idx_reg, wd_reg);
  wire [7:0] first_byte = byte_for(k_reg, i2c_reg, rd_reg, idx_reg, wd_reg);

  // Sampling of the lines coming back from the device
  always_ff @(posedge clk_sys_in) begin
    sdo_sync_reg <= {sdo_sync_reg[0], link.serial_out_line};
    sda_sync_reg <= {sda_sync_reg[0], link.sda_ce};
  end

  // Transaction sequencer, one state step per four quarter ticks
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_reg <= dshp_pkg::H_IDLE;
      q_cnt_reg <= '0;
      phase_reg <= 2'h0;
      k_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      wd_reg <= 8'h00;
      idx_reg <= 7'h00;
      rd_reg <= 1'b0;
      i2c_reg <= 1'b0;
      rec_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_reg <= 1'b0;
      sda_oe_reg <= 1'b1;
      sda_val_reg <= 1'b1;
      done_reg <= 1'b0;
      sdi_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      q_cnt_reg <= tick ? q_load : dshp_pkg::QCNT_W'(q_cnt_reg - 1'b1);
      if (state_reg != dshp_pkg::H_IDLE && tick) begin
        phase_reg <= 2'(phase_reg + 2'h1);
      end
      case (state_reg)
        dshp_pkg::H_IDLE: begin
          i2c_reg <= i2c_mode_in;
          scl_reg <= i2c_mode_in;
          sda_oe_reg <= ~i2c_mode_in; // RULE3
          sda_val_reg <= 1'b1;
          q_cnt_reg <= q_load;
          phase_reg <= 2'h0;
          k_reg <= 2'h0;
          nack_reg <= 1'b0;
          if (recover_in && i2c_mode_in) begin
            rec_reg <= 1'b1; // RULE22
            scl_reg <= 1'b0;
            sda_oe_reg <= 1'b1;
            sda_val_reg <= 1'b0;
            state_reg <= dshp_pkg::H_STOP;
          end else if (cmd_valid_in) begin
            rd_reg <= cmd_read_in;
            idx_reg <= cmd_index_in;
            wd_reg <= cmd_wdata_in;
            sda_val_reg <= ~i2c_mode_in;
            state_reg <= dshp_pkg::H_START;
          end
        end
        dshp_pkg::H_START: begin
          if (tick) begin
            case (phase_reg)
              2'h0: begin
                sda_oe_reg <= 1'b1;
                sda_val_reg <= 1'b0;
              end
              2'h2: scl_reg <= 1'b0;
              2'h3: begin
                bit_cnt_reg <= 4'h0;
                tx_reg <= first_byte;
                rec_reg <= 1'b0;
                if (rec_reg) begin
                  // Keep the line low so the closing stop is a real rising edge
                  sda_oe_reg <= 1'b1; // RULE22
                  sda_val_reg <= 1'b0;
                  k_reg <= last_k;
                  state_reg <= dshp_pkg::H_STOP;
                end else begin
                  sdi_set(first_byte[7]);
                  state_reg <= dshp_pkg::H_BITS;
                end
              end
              default: begin
              end
            endcase
          end
        end
        dshp_pkg::H_BITS: begin
          if (tick) begin
            case (phase_reg)
              2'h0: scl_reg <= 1'b1;
              2'h2: begin
                scl_reg <= 1'b0;
                if (ack_bit) begin
                  nack_reg <= nack_reg | (sda_sync_reg[1] & ~(rd_reg && k_reg == last_k));
                end else begin
                  rx_reg <= {rx_reg[6:0], i2c_reg ? sda_sync_reg[1] : sdo_sync_reg[1]};
                end
              end
              2'h3: begin
                bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                tx_reg <= {tx_reg[6:0], 1'b0};
                if (byte_end && (stop_here || nack_reg)) begin
                  sda_oe_reg <= 1'b1;
                  sda_val_reg <= 1'b0;
                  state_reg <= dshp_pkg::H_STOP;
                end else if (byte_end) begin
                  k_reg <= 2'(k_reg + 2'h1);
                  bit_cnt_reg <= 4'h0;
                  tx_reg <= next_byte;
                  sdi_set(next_byte[7]);
                end else if (bit_cnt_reg == 4'h7) begin
                  sda_oe_reg <= ~i2c_reg; // RULE16
                end else begin
                  sdi_set(tx_reg[6]);
                end
              end
              default: begin
              end
            endcase
          end
        end
        dshp_pkg::H_STOP: begin
          if (tick) begin
            case (phase_reg)
              2'h0: scl_reg <= i2c_reg;
              2'h1: begin
                sda_oe_reg <= ~i2c_reg;
                sda_val_reg <= 1'b1;
              end
              2'h3: begin
                if (rec_reg || (!nack_reg && k_reg != last_k)) begin
                  k_reg <= rec_reg ? k_reg : 2'(k_reg + 2'h1);
                  state_reg <= dshp_pkg::H_START;
                end else begin
                  state_reg <= dshp_pkg::H_DONE;
                end
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
          done_reg <= 1'b1;
          state_reg <= dshp_pkg::H_IDLE;
        end
      endcase
    end
  end

  // Present one data bit on the active data line
  task automatic sdi_set(input logic b);
    sda_oe_reg <= i2c_reg ? ~b : 1'b1;
    sda_val_reg <= i2c_reg ? 1'b0 : sda_val_reg;
    sdi_reg <= b;
  endtask : sdi_set

  assign link.host_scl = scl_reg;
  assign link.host_sda_out = sda_val_reg;
  assign link.host_sda_oe = sda_oe_reg;
  assign link.host_sdi = sdi_reg;
  assign cmd_ready_out = (state_reg == dshp_pkg::H_IDLE) & ~srst_in;
  assign done_out = done_reg;
  assign rdata_out = rx_reg;
  assign nack_out = nack_reg;
endmodule : dshp_host

// ---- verification/dshp_link_checker.sv ----
// Purpose: Checks on the shared link wires of the host port.
// Assumes: Serial clock made from clk_sys_in; strap held static.
// Notes: Serial edges are seen by sampling on clk_sys_in.
`timescale 1ns/100ps
module dshp_link_checker (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic protocol_strap_pin_in,
  input wire logic scl,
  input wire logic sda_ce,
  input wire logic host_sdi,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic dev_sdo,
  input wire logic dev_sdo_oe
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  logic spi_sel;
  logic [2:0] rise_cnt_reg;
  assign spi_sel = !protocol_strap_pin_in;
  // Serial clock rises within one selection, modulo a byte
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || sda_ce) rise_cnt_reg <= 3'h0;
    else if ($rose(scl)) rise_cnt_reg <= rise_cnt_reg + 3'h1;
  end
  // Clock high phase and the wait for the next rise
  sequence s_high;
    scl && $past(scl);
  endsequence
  sequence s_scl_up;
    ##[1:40] $rose(scl);
  endsequence
  a_spi_ce_reset: assert property (spi_sel && sda_ce |-> !dev_sdo_oe)
    else $error("serial output active while deselected");
  a_spi_ce_idle: assert property (spi_sel && sda_ce |-> !scl)
    else $error("serial clock high while deselected");
  a_sdi_on_rise: assert property (spi_sel && $rose(scl) |-> $stable(host_sdi))
    else $error("input line moved at clock rise");
  a_sdo_on_fall: assert property (spi_sel && dev_sdo_oe && $past(dev_sdo_oe)
    && $changed(dev_sdo) |-> $fell(scl)) else $error("output line moved off falling edge");
  a_whole_bytes: assert property (spi_sel && $rose(sda_ce) |-> rise_cnt_reg == 3'h0)
    else $error("selection ended inside a byte");
  a_spi_no_sda: assert property (spi_sel |-> !dev_sda_oe)
    else $error("open-drain line pulled in serial mode");
  a_sda_stable: assert property (s_high ##0 !spi_sel |-> $stable(dev_sda_oe))
    else $error("device moved data line while clock high");
  a_ack_hold: assert property (!spi_sel && $rose(dev_sda_oe)
    |-> dev_sda_oe throughout s_scl_up) else $error("pull-down not held to clock high");
  // After a stop the device must stay off the line for eight cycles, not just at the stop edge itself
  a_stop_free: assert property (s_high ##0 (!spi_sel && $rose(sda_ce)) |-> !dev_sda_oe [*8])
    else $error("device pulling line after stop");
endmodule : dshp_link_checker

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for both ends of the host port.
// Assumes: Strap and host mode always match; modes change only in reset.
// Notes: Bench register file sits behind the device user side.
`timescale 1ns/100ps
module tb;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic strap = 1'b0;
  logic batt = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_index = 7'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic recover = 1'b0;
  logic [7:0] reg_rdata = 8'h00;
  logic cmd_ready, done, nack, reg_wr, reg_rd;
  logic [7:0] rdata, reg_wdata;
  logic [6:0] reg_index, spi_index, idx;
  logic [7:0] mem [0:127];
  logic [7:0] exp_mem [0:127];
  logic [14:0] wr_q [$];
  logic [6:0] rd_q [$];
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 25515;
  dshp_link_if dshp_link_if_i ();
  dshp_host #(.I2C_Q(8)) dshp_host_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .link(dshp_link_if_i), .i2c_mode_in(strap), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read), .cmd_index_in(cmd_index),
    .cmd_wdata_in(cmd_wdata), .recover_in(recover), .done_out(done), .rdata_out(rdata),
    .nack_out(nack));
  dshp_device dshp_device_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .link(dshp_link_if_i), .protocol_strap_pin_in(strap), .battery_mode_in(batt),
    .reg_index_out(reg_index), .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd), .reg_rdata_in(reg_rdata), .spi_index_out(spi_index),
    .spi_rdata_in(mem[spi_index]));
  dshp_link_checker dshp_link_checker_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .protocol_strap_pin_in(strap), .scl(dshp_link_if_i.scl), .sda_ce(dshp_link_if_i.sda_ce),
    .host_sdi(dshp_link_if_i.host_sdi), .host_sda_oe(dshp_link_if_i.host_sda_oe),
    .dev_sda_oe(dshp_link_if_i.dev_sda_oe), .dev_sdo(dshp_link_if_i.dev_sdo),
    .dev_sdo_oe(dshp_link_if_i.dev_sdo_oe));
  // System clock, 8 ns period
  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // Register file: read data follows the index, write strobes checked in order
  always @(posedge clk_sys_in) begin
    reg_rdata <= mem[reg_index];
    if (reg_wr === 1'b1) begin
      mem[reg_index] <= reg_wdata;
      chk_wr({reg_index, reg_wdata}, (wr_q.size() > 0) ? wr_q.pop_front() : 'x);
    end
    if (reg_rd === 1'b1) begin
      chk_wr({reg_index, 8'h00}, {(rd_q.size() > 0) ? rd_q.pop_front() : 7'hx, 8'h00});
    end
  end
  task automatic chk_wr(input logic [14:0] got, input logic [14:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t write strobe %h expected %h", $time, got, exp);
    end
  endtask : chk_wr
  task automatic chk_rd(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t answer %h expected %h", $time, got, exp);
    end
  endtask : chk_rd
  // One host request; rec asks for the bus recovery sequence instead
  task automatic op(input logic rd, input logic [6:0] idx, input logic rec);
    logic [7:0] wd;
    int t;
    wd = 8'($random(seed));
    t = 0;
    while (cmd_ready !== 1'b1) @(posedge clk_sys_in);
    cmd_valid <= !rec;
    recover <= rec;
    cmd_read <= rd;
    cmd_index <= idx;
    cmd_wdata <= wd;
    @(posedge clk_sys_in);
    cmd_valid <= 1'b0;
    recover <= 1'b0;
    if (!rd && !rec && !batt) begin
      exp_mem[idx] = wd;
      wr_q.push_back({idx, wd});
    end
    if (rd && !rec && !batt && strap) rd_q.push_back(idx);
    do begin
      @(posedge clk_sys_in);
      t++;
    end while ((rec ? cmd_ready : done) !== 1'b1 && t < 4000);
    if (t >= 4000) begin
      error_cnt++;
      $display("FAIL %0t no answer from host", $time);
    end
    if (rec) return;
    if (rd) chk_rd({nack, rdata}, batt ? 9'h0ff : {1'b0, exp_mem[idx]});
    else chk_rd({nack, 8'h00}, {batt & strap, 8'h00});
  endtask : op
  task automatic restart(input logic mode);
    srst_in <= 1'b1;
    strap <= mode;
    repeat (5) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask : restart
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_sys_in);
    error_cnt++;
    results();
  end
  // Serial mode then two-wire mode: boundary and random accesses, then battery
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'($random(seed));
      exp_mem[i] = mem[i];
    end
    for (int m = 0; m < 2; m++) begin
      restart(m[0]);
      for (int i = 0; i < 12; i++) begin
        idx = (i < 2) ? 7'h36 : (i == 2) ? 7'h00 : 7'($unsigned($random(seed)) % 55);
        op((i < 3) ? i[0] : 1'($random(seed)), idx, 1'b0);
      end
      batt <= 1'b1;
      op(1'b0, 7'h10, 1'b0);
      if (m == 0) op(1'b1, 7'h10, 1'b0);
      batt <= 1'b0;
      if (m == 1) op(1'b0, 7'h00, 1'b1);
      op(1'b1, 7'h10, 1'b0);
      $display("test %0d finished", m);
    end
    chk_wr(15'(wr_q.size() + rd_q.size()), 15'h0000);
    results();
  end
endmodule : tb
